/* File: shared/vop_params.svh */
// Constants for the video output pixel bus
`ifndef VOP_PARAMS_SVH
`define VOP_PARAMS_SVH

`define VOP_COMP_WIDTH     8
`define VOP_FMT_WIDTH      2
`define VOP_FMT_CODE_24    2'h0
`define VOP_FMT_CODE_16    2'h1
`define VOP_FMT_CODE_8     2'h2
`define VOP_FMT_RESET      2'h0
`define VOP_BUS_RESET      8'h00
`define VOP_SYNC_STAGES    2

`endif

/* File: shared/vop_pkg.sv */
// Types for the video output pixel bus
package vop_pkg;

    typedef logic [7:0] vop_comp_type;

    typedef enum logic [1:0] {
        VOP_FMT_24BIT = 2'h0,
        VOP_FMT_16BIT = 2'h1,
        VOP_FMT_8BIT  = 2'h2
    } vop_fmt_type;

    typedef enum logic {
        VOP_SLOT_CHROMA,
        VOP_SLOT_LUMA
    } vop_slot_type;

endpackage : vop_pkg

/* File: verilog/vop_video_output_pixel_bus.sv */
// Parallel video output port: format packing and falling-edge launch
// Function
// RULE_01: 16-bit: luma on green, chroma on blue
// RULE_02: 8-bit: luma and chroma interleaved on green
// RULE_03: receiver samples 8-bit bus at twice pixel rate
// RULE_04: 24-bit: full pixel on three buses
// RULE_05: outputs change only on clock falling edge
// RULE_06: receiver captures on rising clock edge
// RULE_07: each line's first chroma is blue-difference
`timescale 1ns/10ps
`default_nettype none
`include "vop_params.svh"

module vop_video_output_pixel_bus (
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    input  wire vop_pkg::vop_fmt_type fmt_sel_in,
    input  wire logic                video_output_clock_in,
    input  wire logic                pix_valid_in,
    output logic                     pix_ready_out,
    input  wire logic                pix_line_start_in,
    input  wire vop_pkg::vop_comp_type pix_r_in,
    input  wire vop_pkg::vop_comp_type pix_g_in,
    input  wire vop_pkg::vop_comp_type pix_b_in,
    input  wire logic                pix_hsync_in,
    input  wire logic                pix_vsync_in,
    output logic                     video_output_clock_out,
    output vop_pkg::vop_comp_type    red_bus_out,
    output vop_pkg::vop_comp_type    green_bus_out,
    output vop_pkg::vop_comp_type    blue_bus_out,
    output logic                     data_enable_out,
    output logic                     hsync_out,
    output logic                     vsync_out
);
    import vop_pkg::*;

    // System domain
    vop_fmt_type  fmt_sys_r;
    logic         rst_n_sys_r;

    // Pixel domain synchronisers
    logic         rst_meta_r;
    logic         rst_pix_n_r;
    vop_fmt_type  fmt_meta_r;
    vop_fmt_type  fmt_sync_r;
    vop_fmt_type  fmt_hold_r;
    vop_fmt_type  fmt_pix_r;

    // Pixel domain state
    vop_slot_type slot_r;
    logic         cr_next_r;
    vop_comp_type y_hold_r;
    vop_comp_type red_stage_r;
    vop_comp_type green_stage_r;
    vop_comp_type blue_stage_r;
    logic         de_stage_r;
    logic         hs_stage_r;
    logic         vs_stage_r;

    logic         take;
    logic         cr_pick;
    vop_comp_type chroma;
    vop_comp_type red_nxt;
    vop_comp_type green_nxt;
    vop_comp_type blue_nxt;
    logic         de_nxt;

    // Registered once so the pixel side sees a clean level
    always_ff @(posedge clk_sys_in) begin
        rst_n_sys_r <= rst_n_in;
    end

    // Format held here, then crossed as one word
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            fmt_sys_r <= vop_fmt_type'(`VOP_FMT_RESET);
        end else begin
            fmt_sys_r <= fmt_sel_in;
        end
    end

    // Reset crosses into the pixel clock through two flops
    always_ff @(posedge video_output_clock_in) begin
        rst_meta_r  <= rst_n_sys_r;
        rst_pix_n_r <= rst_meta_r;
    end

    // Two format bits may skew; apply only a value seen twice in a row
    always_ff @(posedge video_output_clock_in) begin
        if (!rst_pix_n_r) begin
            fmt_meta_r <= vop_fmt_type'(`VOP_FMT_RESET);
            fmt_sync_r <= vop_fmt_type'(`VOP_FMT_RESET);
            fmt_hold_r <= vop_fmt_type'(`VOP_FMT_RESET);
            fmt_pix_r  <= vop_fmt_type'(`VOP_FMT_RESET);
        end else begin
            fmt_meta_r <= fmt_sys_r;
            fmt_sync_r <= fmt_meta_r;
            fmt_hold_r <= fmt_sync_r;
            if (fmt_sync_r == fmt_hold_r) begin
                fmt_pix_r <= fmt_hold_r;
            end
        end
    end

    // RULE_03: one input pixel per two clocks in 8-bit
    assign pix_ready_out = rst_pix_n_r &&
                           ((fmt_pix_r != VOP_FMT_8BIT) || (slot_r == VOP_SLOT_CHROMA));
    assign take          = pix_valid_in && pix_ready_out;

    // RULE_07: line start forces blue-difference
    assign cr_pick = pix_line_start_in ? 1'b0 : cr_next_r;
    assign chroma  = cr_pick ? pix_r_in : pix_b_in;

    // Bus contents for the next launch, per format
    always_comb begin
        red_nxt   = `VOP_BUS_RESET;
        green_nxt = `VOP_BUS_RESET;
        blue_nxt  = `VOP_BUS_RESET;
        de_nxt    = 1'b0;
        case (fmt_pix_r)
            VOP_FMT_24BIT: begin
                // RULE_04: full pixel per clock
                if (take) begin
                    red_nxt   = pix_r_in;
                    green_nxt = pix_g_in;
                    blue_nxt  = pix_b_in;
                    de_nxt    = 1'b1;
                end
            end
            VOP_FMT_16BIT: begin
                // RULE_01: luma green, chroma blue
                if (take) begin
                    green_nxt = pix_g_in;
                    blue_nxt  = chroma;
                    de_nxt    = 1'b1;
                end
            end
            VOP_FMT_8BIT: begin
                // RULE_02: chroma slot then luma slot
                if (slot_r == VOP_SLOT_LUMA) begin
                    green_nxt = y_hold_r;
                    de_nxt    = 1'b1;
                end else if (take) begin
                    green_nxt = chroma;
                    de_nxt    = 1'b1;
                end
            end
            default: begin
                // Idle code: buses stay at zero
                de_nxt = 1'b0;
            end
        endcase
    end

    // Byte slot: chroma first, held luma next clock
    always_ff @(posedge video_output_clock_in) begin
        if (!rst_pix_n_r) begin
            slot_r   <= VOP_SLOT_CHROMA;
            y_hold_r <= `VOP_BUS_RESET;
        end else if (fmt_pix_r != VOP_FMT_8BIT) begin
            slot_r   <= VOP_SLOT_CHROMA;
        end else if (slot_r == VOP_SLOT_LUMA) begin
            slot_r   <= VOP_SLOT_CHROMA;
        end else if (take) begin
            slot_r   <= VOP_SLOT_LUMA;
            y_hold_r <= pix_g_in;
        end
    end

    // RULE_07: chroma alternates per accepted pixel
    always_ff @(posedge video_output_clock_in) begin
        if (!rst_pix_n_r) begin
            cr_next_r <= 1'b0;
        end else if (take) begin
            cr_next_r <= ~cr_pick;
        end
    end

    // Staged on the rise; syncs share the data latency
    always_ff @(posedge video_output_clock_in) begin
        if (!rst_pix_n_r) begin
            red_stage_r   <= `VOP_BUS_RESET;
            green_stage_r <= `VOP_BUS_RESET;
            blue_stage_r  <= `VOP_BUS_RESET;
            de_stage_r    <= 1'b0;
            hs_stage_r    <= 1'b0;
            vs_stage_r    <= 1'b0;
        end else begin
            red_stage_r   <= red_nxt;
            green_stage_r <= green_nxt;
            blue_stage_r  <= blue_nxt;
            de_stage_r    <= de_nxt;
            hs_stage_r    <= pix_hsync_in;
            vs_stage_r    <= pix_vsync_in;
        end
    end

    // Half a clock of margin around the receiver's rise
    // RULE_05: launch on falling edge only
    always_ff @(negedge video_output_clock_in) begin
        if (!rst_pix_n_r) begin
            red_bus_out     <= `VOP_BUS_RESET;
            green_bus_out   <= `VOP_BUS_RESET;
            blue_bus_out    <= `VOP_BUS_RESET;
            data_enable_out <= 1'b0;
            hsync_out       <= 1'b0;
            vsync_out       <= 1'b0;
        end else begin
            red_bus_out     <= red_stage_r;
            green_bus_out   <= green_stage_r;
            blue_bus_out    <= blue_stage_r;
            data_enable_out <= de_stage_r;
            hsync_out       <= hs_stage_r;
            vsync_out       <= vs_stage_r;
        end
    end

    // RULE_06: forwarded clock, receiver samples on its rise
    assign video_output_clock_out = video_output_clock_in;

endmodule : vop_video_output_pixel_bus
`default_nettype wire

/* File: test/vop_checker.sv */
// Port checks for the video output pixel bus
`timescale 1ns/10ps
`default_nettype none
module vop_checker (
    input wire logic                  video_output_clock_in,
    input wire logic                  rst_n_in,
    input wire vop_pkg::vop_fmt_type  fmt_sel_in,
    input wire logic                  pix_valid_in,
    input wire logic                  pix_ready_out,
    input wire logic                  pix_line_start_in,
    input wire vop_pkg::vop_comp_type pix_r_in,
    input wire vop_pkg::vop_comp_type pix_g_in,
    input wire vop_pkg::vop_comp_type pix_b_in,
    input wire logic                  pix_hsync_in,
    input wire logic                  pix_vsync_in,
    input wire vop_pkg::vop_comp_type red_bus_out,
    input wire vop_pkg::vop_comp_type green_bus_out,
    input wire vop_pkg::vop_comp_type blue_bus_out,
    input wire logic                  data_enable_out,
    input wire logic                  hsync_out,
    input wire logic                  vsync_out
);
    import vop_pkg::*;
    logic        rst_meta_r;
    logic        rst_pix_n_r;
    logic        take;
    logic        ls_take;
    logic [26:0] rise_r;
    default clocking @(posedge video_output_clock_in); endclocking
    default disable iff (!rst_n_in || !rst_pix_n_r);
    // Reset brought into the pixel clock before it releases the checks
    always_ff @(posedge video_output_clock_in) begin
        rst_meta_r  <= rst_n_in;
        rst_pix_n_r <= rst_meta_r;
    end
    assign take = pix_valid_in & pix_ready_out;
    assign ls_take = take & pix_line_start_in;
    always_ff @(posedge video_output_clock_in)
        rise_r <= {red_bus_out, green_bus_out, blue_bus_out, data_enable_out,
                   hsync_out, vsync_out};
    fall_launch_a: assert property (@(negedge video_output_clock_in)
        {red_bus_out, green_bus_out, blue_bus_out, data_enable_out, hsync_out, vsync_out}
        == rise_r)
        else $error("bus changed on rising edge");
    full_pixel_a: assert property (fmt_sel_in == VOP_FMT_24BIT && $past(take) |->
        data_enable_out && green_bus_out == $past(pix_g_in)
        && {red_bus_out, blue_bus_out} == {$past(pix_r_in), $past(pix_b_in)})
        else $error("full pixel wrong");
    luma_lane_a: assert property (fmt_sel_in == VOP_FMT_16BIT && $past(take) |->
        data_enable_out && green_bus_out == $past(pix_g_in) && red_bus_out == 8'h00)
        else $error("16-bit lanes wrong");
    first_cb_a: assert property (fmt_sel_in == VOP_FMT_16BIT && $past(ls_take) |->
        blue_bus_out == $past(pix_b_in)) else $error("line did not start with Cb");
    byte_lane_a: assert property (fmt_sel_in == VOP_FMT_8BIT && $past(ls_take) |->
        green_bus_out == $past(pix_b_in) && blue_bus_out == 8'h00
        ##1 data_enable_out && green_bus_out == $past(pix_g_in, 2))
        else $error("8-bit interleave wrong");
    luma_refuse_a: assert property (fmt_sel_in == VOP_FMT_8BIT && take |=>
        !pix_ready_out) else $error("pixel accepted in luma slot");
    sync_pass_a: assert property ({hsync_out, vsync_out}
        == $past({pix_hsync_in, pix_vsync_in})) else $error("sync latency wrong");
endmodule : vop_checker
bind vop_video_output_pixel_bus vop_checker chk_u (
    .video_output_clock_in (video_output_clock_in),
    .rst_n_in              (rst_n_in),
    .fmt_sel_in            (fmt_sel_in),
    .pix_valid_in          (pix_valid_in),
    .pix_ready_out         (pix_ready_out),
    .pix_line_start_in     (pix_line_start_in),
    .pix_r_in              (pix_r_in),
    .pix_g_in              (pix_g_in),
    .pix_b_in              (pix_b_in),
    .pix_hsync_in          (pix_hsync_in),
    .pix_vsync_in          (pix_vsync_in),
    .red_bus_out           (red_bus_out),
    .green_bus_out         (green_bus_out),
    .blue_bus_out          (blue_bus_out),
    .data_enable_out       (data_enable_out),
    .hsync_out             (hsync_out),
    .vsync_out             (vsync_out)
);
`default_nettype wire

/* File: test/vop_rx_model.sv */
// Receiver model that captures the pixel bus
`timescale 1ns/10ps
`default_nettype none
module vop_rx_model (
    input  wire logic        clk_in,
    input  wire logic [23:0] bus_in,
    input  wire logic        de_in,
    output logic [24:0]      cap_out
);
    always_ff @(posedge clk_in) cap_out <= {bus_in, de_in};
endmodule : vop_rx_model
`default_nettype wire

/* File: test/video_output_pixel_bus_tb.sv */
// Self-checking bench for the video output pixel bus
`timescale 1ns/10ps
`default_nettype none
module video_output_pixel_bus_tb;
    import vop_pkg::*;
    logic         clk_sys_in = 1'h0, vclk = 1'h0, rst_n_in = 1'h0, valid = 1'h0, ls = 1'h0;
    logic         hs = 1'h0, vs = 1'h0, sync_on = 1'h0, hso, vso;
    logic [1:0]   sync_h1 = 2'h0, sync_h2 = 2'h0;
    vop_fmt_type  fmt = VOP_FMT_24BIT;
    vop_comp_type r = 8'h00, g = 8'h00, b = 8'h00;
    logic         ready, fclk, de, tk, ph;
    logic [23:0]  bus;
    logic [24:0]  cap;
    logic [23:0]  q[$];
    int           n_errors = 0, checks = 0, k;
    always #5 clk_sys_in = ~clk_sys_in;
    always #6 vclk = ~vclk;
    vop_video_output_pixel_bus dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .fmt_sel_in(fmt), .video_output_clock_in(vclk), .pix_valid_in(valid),
        .pix_ready_out(ready), .pix_line_start_in(ls), .pix_r_in(r), .pix_g_in(g),
        .pix_b_in(b), .pix_hsync_in(hs), .pix_vsync_in(vs), .video_output_clock_out(fclk),
        .red_bus_out(bus[23:16]), .green_bus_out(bus[15:8]), .blue_bus_out(bus[7:0]),
        .data_enable_out(de), .hsync_out(hso), .vsync_out(vso));
    vop_rx_model rx_u (.clk_in(fclk), .bus_in(bus), .de_in(de), .cap_out(cap));
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t bus %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_sync(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t sync %b expected %b", $time, got, exp);
        end
    endtask : cmp_sync
    task automatic report_and_stop(input bit hang);
        if (hang) begin
            n_errors++;
            $display("MISMATCH %0t wait ran out", $time);
        end
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    always @(posedge vclk) begin
        #2;
        if (cap[0] === 1'h1)
            cmp(cap[24:1], q.size() > 0 ? q.pop_front() : ~cap[24:1]);
    end
    // Syncs: two-deep history of what the design sampled
    always @(posedge vclk) begin
        #2;
        if (sync_on) cmp_sync({hso, vso}, sync_h2);
        sync_h2 = sync_h1;
        sync_h1 = {hs, vs};
    end
    task automatic send_line(input vop_fmt_type f);
        @(posedge clk_sys_in);
        #1 fmt = f;
        repeat (10) @(posedge vclk);
        #1;
        for (int i = 0; i < 9; i++) begin
            valid = 1'h1;
            ls = (i == 0);
            {r, g, b} = 24'($urandom);
            {hs, vs} = 2'($urandom);
            k = 0;
            do begin
                #1 tk = ready;
                @(posedge vclk);
                #1 k++;
            end while (tk !== 1'h1 && k < 20);
            if (k >= 20) report_and_stop(1);
            ph = ls ? 1'h0 : ph;
            if (f == VOP_FMT_24BIT) q.push_back({r, g, b});
            else if (f == VOP_FMT_16BIT) q.push_back({8'h00, g, ph ? r : b});
            else begin
                q.push_back({8'h00, ph ? r : b, 8'h00});
                q.push_back({8'h00, g, 8'h00});
            end
            ph = ~ph;
        end
        valid = 1'h0;
        for (k = 0; k < 50 && q.size() > 0; k++) @(posedge vclk);
        if (q.size() > 0) report_and_stop(1);
    endtask : send_line
    initial begin
        void'($urandom(32'h191C693B));
        repeat (8) @(posedge clk_sys_in);
        #1 rst_n_in = 1'h1;
        repeat (6) @(posedge vclk);
        sync_on = 1'h1;
        repeat (2) begin
            send_line(VOP_FMT_24BIT);
            send_line(VOP_FMT_16BIT);
            send_line(VOP_FMT_8BIT);
        end
        report_and_stop(0);
    end
endmodule : video_output_pixel_bus_tb
`default_nettype wire
